// ### verilog/slo_pkg.sv
/*
 * slo_pkg: constants for the shift-latch sink output driver.
 * assumes a single 250 MHz system clock; external pins are asynchronous.
 */
`default_nettype none
package slo_pkg;
    localparam int CHANNELS        = 16;
    localparam int SYNC_STAGES     = 2;
    localparam int BUF_DEPTH       = 2;
    localparam int CLK_PERIOD_PS   = 4000;
    // cascade shift clock ceiling, MHz
    localparam int SHIFT_MAX_MHZ   = 15;
    localparam int SHIFT_MIN_PS    = 1000000 / SHIFT_MAX_MHZ;
    localparam int SHIFT_MIN_CYC   = (SHIFT_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [15:0] SHIFT_RESET = 16'h0000;
    localparam logic [15:0] LATCH_RESET = 16'h0000;
    localparam logic [15:0] SINKS_OFF   = 16'h0000;
endpackage : slo_pkg
`default_nettype wire

// ### verilog/slo_buf.sv
/*
 * slo_buf: two-entry valid/ready buffer carrying shifted words.
 * assumes producer and consumer on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module slo_buf #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    // fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    function automatic logic [AW-1:0] slo_inc(input logic [AW-1:0] p);
        slo_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : slo_inc

    assign in_ready_out  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid_out = (count_reg != '0);
    assign push = in_valid_in && in_ready_out;
    assign pop  = out_valid_out && out_ready_in;
    assign out_data_out = mem_reg[rd_ptr_reg];

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= slo_inc(wr_ptr_reg);
            end
            if (pop) begin
                rd_ptr_reg <= slo_inc(rd_ptr_reg);
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    AST_NO_OVERFLOW: assert property (@(posedge clk_in) disable iff (rst_in)
        count_reg <= (AW+1)'(DEPTH))
        else $error("buffer count above depth");
endmodule : slo_buf
`default_nettype wire

// ### verilog/slo_driver.sv
/*
 * slo_driver: 16-stage serial shift register, level latch, blanking gate.
 * assumes pins are asynchronous and sampled on ref_clk_in at 250 MHz;
 * analogue current setting is outside this logic.
 */
`timescale 1ns/1ps
`default_nettype none
module slo_driver #(
    parameter int CHANNELS = slo_pkg::CHANNELS
) (
    // clock and reset
    input  wire logic                ref_clk_in,
    input  wire logic                rst_in,
    // serial pins from controller
    input  wire logic                shift_data_in,
    input  wire logic                shift_clk_in,
    input  wire logic                latch_strobe_in,
    input  wire logic                blank_in,
    // outputs
    output logic [CHANNELS-1:0]      sink_outputs_out,
    output logic                     cascade_data_out,
    // diagnostics
    output logic                     shift_too_fast_out
);
    logic [slo_pkg::SYNC_STAGES-1:0] data_sync_reg;
    logic [slo_pkg::SYNC_STAGES-1:0] sclk_sync_reg;
    logic [slo_pkg::SYNC_STAGES-1:0] strb_sync_reg;
    logic [slo_pkg::SYNC_STAGES-1:0] blank_sync_reg;
    logic                            sclk_last_reg;
    logic                            shift_edge;
    logic [CHANNELS-1:0]             shift_reg;
    logic [CHANNELS-1:0]             shift_next;
    logic [CHANNELS-1:0]             latch_reg;
    logic [CHANNELS-1:0]             buf_data;
    logic                            buf_in_ready;
    logic                            buf_out_valid;
    logic [7:0]                      gap_cnt_reg;
    logic                            gap_seen_reg;

    // two flops on every pin; only the second flop feeds logic
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            data_sync_reg  <= '0;
            sclk_sync_reg  <= '0;
            strb_sync_reg  <= '0;
            blank_sync_reg <= '1;
        end else begin
            data_sync_reg  <= {data_sync_reg[0], shift_data_in};
            sclk_sync_reg  <= {sclk_sync_reg[0], shift_clk_in};
            strb_sync_reg  <= {strb_sync_reg[0], latch_strobe_in};
            blank_sync_reg <= {blank_sync_reg[0], blank_in};
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            sclk_last_reg <= 1'b0;
        end else begin
            sclk_last_reg <= sclk_sync_reg[1];
        end
    end

    // data sampled two flops late, matching the clock path delay
    assign shift_edge = sclk_sync_reg[1] && !sclk_last_reg;
    assign shift_next = {shift_reg[CHANNELS-2:0], data_sync_reg[1]};

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            shift_reg <= slo_pkg::SHIFT_RESET;
        end else if (shift_edge) begin
            shift_reg <= shift_next;
        end
    end

    assign cascade_data_out = shift_reg[CHANNELS-1];

    // latch reads through the buffer: one cycle lag, both sides always ready
    slo_buf #(
        .WIDTH (CHANNELS),
        .DEPTH (slo_pkg::BUF_DEPTH)
    ) u_buf (
        .clk_in        (ref_clk_in),
        .rst_in        (rst_in),
        .in_valid_in   (1'b1),
        .in_ready_out  (buf_in_ready),
        .in_data_in    (shift_reg),
        .out_valid_out (buf_out_valid),
        .out_ready_in  (1'b1),
        .out_data_out  (buf_data)
    );

    // level sensitive: copies every cycle strobe is high, no edge needed
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            latch_reg <= slo_pkg::LATCH_RESET;
        end else if (strb_sync_reg[1] && buf_out_valid) begin
            latch_reg <= buf_data;
        end
    end

    // blanking is registered; one cycle lag is far below pin delays
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            sink_outputs_out <= slo_pkg::SINKS_OFF;
        end else if (blank_sync_reg[1]) begin
            sink_outputs_out <= slo_pkg::SINKS_OFF;
        end else begin
            sink_outputs_out <= latch_reg;
        end
    end

    // flags shift clock edges closer than the cascade limit
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            gap_cnt_reg  <= '0;
            gap_seen_reg <= 1'b0;
            shift_too_fast_out <= 1'b0;
        end else if (shift_edge) begin
            gap_cnt_reg  <= '0;
            gap_seen_reg <= 1'b1;
            shift_too_fast_out <= gap_seen_reg &&
                (gap_cnt_reg < 8'(slo_pkg::SHIFT_MIN_CYC - 1));
        end else if (gap_cnt_reg != 8'hFF) begin
            gap_cnt_reg <= gap_cnt_reg + 8'h01;
        end
    end

    AST_SHIFT_MOVES: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        shift_edge |=> shift_reg == $past(shift_next))
        else $error("shift register did not advance");
    AST_SHIFT_HOLDS: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !shift_edge |=> $stable(shift_reg))
        else $error("shift register moved without clock edge");
    AST_LATCH_PASS: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        strb_sync_reg[1] && buf_out_valid |=> latch_reg == $past(shift_reg, 2))
        else $error("latch not transparent");
    AST_LATCH_HOLD: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !strb_sync_reg[1] |=> $stable(latch_reg))
        else $error("latch changed while held");
    AST_BLANK_OFF: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        blank_sync_reg[1] |=> sink_outputs_out == slo_pkg::SINKS_OFF)
        else $error("sinks not off under blanking");
    AST_SINK_FOLLOW: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !blank_sync_reg[1] |=> sink_outputs_out == $past(latch_reg))
        else $error("sinks do not follow latch");
    AST_BIT_ORDER: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        shift_edge |=> shift_reg[0] == $past(data_sync_reg[1]))
        else $error("newest bit not at output zero");
    AST_CASCADE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        shift_edge |=> cascade_data_out == $past(shift_reg[CHANNELS-2]))
        else $error("cascade output wrong stage");
    AST_BUF_FLOW: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        buf_out_valid |-> buf_data == $past(shift_reg))
        else $error("buffer handshake broken");
endmodule : slo_driver
`default_nettype wire

// ### verification/slo_ctrl_model.sv
/*
 * slo_ctrl_model: display controller driving the serial pins of slo_driver.
 * assumes ref_clk_in at 250 MHz; pins change only at its falling edge.
 */
`timescale 1ns/1ps
`default_nettype none
module slo_ctrl_model (
    // clock
    input  wire logic ref_clk_in,
    // pins to driver
    output logic      shift_data_out,
    output logic      shift_clk_out,
    output logic      latch_strobe_out,
    output logic      blank_out
);
    initial begin
        shift_data_out   = 1'b0;
        shift_clk_out    = 1'b0;
        latch_strobe_out = 1'b0;
        blank_out        = 1'b1;
    end
    // half period h >= 9 cycles keeps the rate under 15 MHz
    task automatic shift_bit(input logic b, input int h);
        shift_data_out = b;
        repeat (h) @(negedge ref_clk_in);
        shift_clk_out = 1'b1;
        repeat (h) @(negedge ref_clk_in);
        shift_clk_out  = 1'b0;
        // hold long over: data not kept
        shift_data_out = ~b;
    endtask : shift_bit
    task automatic strobe_pulse();
        latch_strobe_out = 1'b1;
        repeat (4) @(negedge ref_clk_in);
        latch_strobe_out = 1'b0;
        repeat (8) @(negedge ref_clk_in);
    endtask : strobe_pulse
    task automatic set_level(input logic s, input logic b);
        latch_strobe_out = s;
        blank_out        = b;
        repeat (8) @(negedge ref_clk_in);
    endtask : set_level
endmodule : slo_ctrl_model
`default_nettype wire

// ### verification/shift_latch_output_driver_bench.sv
/*
 * shift_latch_output_driver_bench: self-checking bench for slo_driver.
 * assumes slo_ctrl_model drives the pins; expected words queued by driver side.
 */
`timescale 1ns/1ps
`default_nettype none
module shift_latch_output_driver_bench;
    logic        ref_clk_in, rst_in, sd, sc, ls, bl, casc, fast, exp_fast;
    logic [15:0] sinks, sr, lat, word;
    logic [17:0] q[$];
    int          errors, num_checks, seed;
    event        look;
    slo_ctrl_model ctrl (.ref_clk_in(ref_clk_in), .shift_data_out(sd), .shift_clk_out(sc),
                         .latch_strobe_out(ls), .blank_out(bl));
    slo_driver dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .shift_data_in(sd), .shift_clk_in(sc),
                    .latch_strobe_in(ls), .blank_in(bl), .sink_outputs_out(sinks),
                    .cascade_data_out(casc), .shift_too_fast_out(fast));
    initial begin
        ref_clk_in = 1'b0;
        forever #2 ref_clk_in = ~ref_clk_in;
    end
    task automatic check(input logic [17:0] seen, input logic [17:0] want);
        num_checks++;
        if (seen !== want) begin
            errors++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic note(input logic [15:0] s);
        q.push_back({exp_fast, sr[15], s});
        ->look;
    endtask : note
    always @(look) begin
        check({fast, casc, sinks}, q.pop_front());
    end
    task automatic send(input logic b, input int h);
        ctrl.shift_bit(b, h);
        sr = {sr[14:0], b};
    endtask : send
    task automatic report_and_stop();
        $display("checks %0d, errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        errors++;
        report_and_stop();
    end
    initial begin
        seed       = 20305;
        rst_in     = 1'b1;
        errors     = 0;
        num_checks = 0;
        sr         = 16'h0000;
        lat        = 16'h0000;
        exp_fast   = 1'b0;
        repeat (10) @(negedge ref_clk_in);
        rst_in = 1'b0;
        ctrl.set_level(1'b0, 1'b0);
        note(16'h0000);
        $display("test reset done");
        for (int w = 0; w < 4; w++) begin
            word = 16'($random(seed));
            // newest bit last, so sink0 ends up with word[0]
            for (int i = 15; i >= 0; i--) send(word[i], 9 + int'($unsigned($random(seed)) % 4));
            note(lat);
            ctrl.strobe_pulse();
            lat = sr;
            note(word);
        end
        $display("test words done");
        ctrl.set_level(1'b1, 1'b0);
        lat = sr;
        note(lat);
        for (int k = 0; k < 3; k++) begin
            send(word[k] ^ 1'b1, 9);
            lat = sr;
            note(lat);
        end
        ctrl.set_level(1'b0, 1'b0);
        $display("test transparent done");
        ctrl.set_level(1'b0, 1'b1);
        note(16'h0000);
        send(1'b1, 10);
        note(16'h0000);
        ctrl.set_level(1'b0, 1'b0);
        note(lat);
        $display("test blank done");
        // second edge only eight cycles after the first: flagged
        send(1'b1, 4);
        exp_fast = 1'b1;
        send(1'b0, 4);
        note(lat);
        ctrl.set_level(1'b0, 1'b0);
        exp_fast = 1'b0;
        send(1'b1, 9);
        note(lat);
        $display("test rate done");
        // mid-run reset clears shift stages, latch and rate flag
        rst_in = 1'b1;
        repeat (3) @(negedge ref_clk_in);
        rst_in = 1'b0;
        sr  = 16'h0000;
        lat = 16'h0000;
        ctrl.set_level(1'b0, 1'b0);
        note(16'h0000);
        $display("test rerun reset done");
        report_and_stop();
    end
endmodule : shift_latch_output_driver_bench
`default_nettype wire
